// ### common/vrag_if.sv
// Link between the refresh controller and the host side.
// Assumes both ends share clk_in.
`timescale 1ns/1ps
`default_nettype none
interface vrag_if;
  logic [15:0] refresh_ram_address;
  logic [7:0] plane_red;
  logic [7:0] plane_green;
  logic [7:0] plane_blue;
  logic [15:0] start_address;
  logic start_load;
  logic retrace;
  logic vert_irq;
  logic [15:0] video_ram_address;
  logic [15:0] host_logical_address;
  logic hidden_select;
  logic ram_64k;
  modport dev (
    output refresh_ram_address, retrace, vert_irq, video_ram_address,
    input plane_red, plane_green, plane_blue, start_address, start_load,
    input host_logical_address, hidden_select, ram_64k
  );
  modport host (
    input refresh_ram_address, retrace, vert_irq, video_ram_address,
    output plane_red, plane_green, plane_blue, start_address, start_load,
    output host_logical_address, hidden_select, ram_64k
  );
endinterface : vrag_if
`default_nettype wire

// ### common/vrag_pkg.sv
// Shared constants and types for the video refresh address generator.
// Assumes a single 10 MHz clock and an active low asynchronous reset.
// Behaviour
// R1: Address is refresh address over scan count.
// R2: Each byte gives eight pixels, then steps.
// R3: Sweep row columns per scan, nine scans.
// R4: Next row base after last scan line.
// R5: Reload start address after vertical retrace.
// R6: Nine scans, 80 bytes, 25 rows configured.
// R7: Full screen refreshed sixty times per second.
// R8: Byte offset is column times 16 plus scan.
// R9: Host scrolls by adding 1280 to start.
// R10: Host clears bottom row during retrace first; vrag_host clears nothing, it only steps start.
// R11: Host changes start only during retrace.
// R12: Interrupt raised at vertical retrace.
// R13: Reverse video complements every pixel bit.
// R14: Three planes share address, own shifters.
// R15: Planes hold 32 or 64 kilobytes.
// R16: Host reaches video RAM through remapping.
// R17: Host columns 50 to 7f not stored; vrag_device folds them to row times 300h plus (column - 50h) times 16.
// R18: With 32K parts non-displayed areas wrap.
// R19: Host reaches hidden areas via latch 80h.
// R20: Start address is zero after reset.
package vrag_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned FRAME_HZ = 60;
  localparam int unsigned PIXELS_PER_BYTE = 8;
  localparam int unsigned BYTES_PER_LINE = 80;
  localparam int unsigned SCANS_PER_ROW = 9;
  localparam int unsigned ROWS_PER_SCREEN = 25;
  localparam int unsigned SCAN_STRIDE = 16;
  localparam int unsigned ROW_STRIDE = BYTES_PER_LINE * SCAN_STRIDE;
  localparam int unsigned HOST_COLS = 128;
  localparam int unsigned ACTIVE_CYCLES =
    ROWS_PER_SCREEN * SCANS_PER_ROW * BYTES_PER_LINE * PIXELS_PER_BYTE;
  localparam int unsigned FRAME_CYCLES = CLK_HZ / FRAME_HZ;
  localparam int unsigned RETRACE_CYCLES = FRAME_CYCLES - ACTIVE_CYCLES;
  localparam logic [15:0] START_RESET = 16'h0000;
  localparam logic [7:0] HIDDEN_LATCH = 8'h80;
  localparam logic [2:0] PIX_LAST = 3'h7;
  localparam logic [3:0] SCAN_LAST = 4'h8;
  localparam logic [6:0] COL_LAST = 7'h4f;
  localparam logic [4:0] ROW_LAST = 5'h18;
  typedef enum logic [1:0] {
    VRAG_ACTIVE = 2'b00,
    VRAG_RETRACE = 2'b01
  } vrag_phase_type;
endpackage : vrag_pkg

// ### rtl/vrag_device.sv
// Refresh address generator with pixel shifters and host address remap.
// Assumes plane data arrives from RAM the cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module vrag_device (
  input wire logic clk_in,
  input wire logic arst_n_in,
  vrag_if.dev link,
  input wire logic reverse_in,
  output logic [2:0] rgb_out,
  output logic active_out
);
  import vrag_pkg::*;

  logic [15:0] start_q;
  logic [15:0] row_base_q;
  logic [6:0] col_q;
  logic [3:0] scan_q;
  logic [4:0] row_q;
  logic [2:0] pix_q;
  logic [31:0] ret_cnt_q;
  vrag_phase_type phase_q;
  logic [7:0] sh_r_q;
  logic [7:0] sh_g_q;
  logic [7:0] sh_b_q;
  logic load_q;
  logic [11:0] refresh_memory_address;
  logic [15:0] host_phys;

  // Start register; zero after reset, loaded by the host.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_q <= START_RESET; // R20
    end else if (link.start_load) begin
      start_q <= link.start_address;
    end
  end

  // Pixel, column, scan and row counters walk the frame.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_q <= VRAG_ACTIVE;
      pix_q <= 3'h0;
      col_q <= 7'h00;
      scan_q <= 4'h0;
      row_q <= 5'h00;
      row_base_q <= START_RESET;
      ret_cnt_q <= 32'h0;
    end else begin
      case (phase_q)
        VRAG_ACTIVE: begin
          pix_q <= pix_q + 3'h1; // R2
          if (pix_q == PIX_LAST) begin
            if (col_q != COL_LAST) begin
              col_q <= col_q + 7'h01; // R3
            end else begin
              col_q <= 7'h00;
              if (scan_q != SCAN_LAST) begin
                scan_q <= scan_q + 4'h1; // R3
              end else begin
                scan_q <= 4'h0;
                row_base_q <= row_base_q + 16'(ROW_STRIDE); // R4
                if (row_q != ROW_LAST) begin
                  row_q <= row_q + 5'h01; // R6
                end else begin
                  row_q <= 5'h00;
                  phase_q <= VRAG_RETRACE; // R4
                  ret_cnt_q <= 32'h0;
                end
              end
            end
          end
        end
        VRAG_RETRACE: begin
          ret_cnt_q <= ret_cnt_q + 32'h1;
          if (ret_cnt_q == RETRACE_CYCLES - 1) begin // R7
            row_base_q <= start_q; // R5
            phase_q <= VRAG_ACTIVE;
          end
        end
        default: begin
          phase_q <= VRAG_ACTIVE;
        end
      endcase
    end
  end

  // Word address of the current byte within the refresh space.
  assign refresh_memory_address = 12'(row_base_q[15:4]
    + 12'(col_q)); // R8

  // Address goes out registered: refresh address above scan count.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link.refresh_ram_address <= 16'h0000;
    end else begin
      link.refresh_ram_address <= {refresh_memory_address,
        scan_q + row_base_q[3:0]}; // R1
    end
  end

  // Load strobe marks the cycle when fetched plane bytes are present.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      load_q <= 1'b0;
    end else begin
      load_q <= (phase_q == VRAG_ACTIVE) && (pix_q == 3'h0);
    end
  end

  // One shift register per plane, most significant pixel first.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sh_r_q <= 8'h00;
      sh_g_q <= 8'h00;
      sh_b_q <= 8'h00;
    end else if (load_q) begin
      sh_r_q <= link.plane_red; // R14
      sh_g_q <= link.plane_green;
      sh_b_q <= link.plane_blue;
    end else begin
      sh_r_q <= {sh_r_q[6:0], 1'b0};
      sh_g_q <= {sh_g_q[6:0], 1'b0};
      sh_b_q <= {sh_b_q[6:0], 1'b0};
    end
  end

  // Pixel output, complemented under reverse video; blank in retrace.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rgb_out <= 3'h0;
      active_out <= 1'b0;
    end else begin
      active_out <= (phase_q == VRAG_ACTIVE);
      if (phase_q == VRAG_ACTIVE) begin
        rgb_out <= {sh_r_q[7], sh_g_q[7], sh_b_q[7]}
          ^ {3{reverse_in}}; // R13
      end else begin
        rgb_out <= 3'h0;
      end
    end
  end

  // Retrace level and interrupt for the host to time start updates.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link.retrace <= 1'b0;
      link.vert_irq <= 1'b0;
    end else begin
      link.retrace <= (phase_q == VRAG_RETRACE);
      link.vert_irq <= (phase_q == VRAG_RETRACE)
        && (ret_cnt_q == 32'h0); // R12
    end
  end

  // Host remap: column times 16 plus scan line; columns 50..7f fold to row times 300h plus (column - 50h) times 16.
  always_comb begin
    logic [8:0] line;
    logic [6:0] col;
    line = link.host_logical_address[15:7];
    col = link.host_logical_address[6:0];
    host_phys = 16'(line[8:4]) * 16'(ROW_STRIDE)
      + 16'(col) * 16'(SCAN_STRIDE) + 16'(line[3:0]); // R16
    if (col > COL_LAST) begin
      host_phys = 16'(col - 7'h50) * 16'(SCAN_STRIDE)
        + 16'(line[3:0]) + 16'(line[8:4]) * 16'h0300; // R17
    end
    host_phys = host_phys + start_q;
    if (link.hidden_select && link.ram_64k) begin
      host_phys = host_phys + {HIDDEN_LATCH, 8'h00}; // R19
    end
    if (!link.ram_64k) begin
      host_phys[15] = 1'b0; // R18 R15
    end
  end

  // Remapped host address is registered toward the RAM.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link.video_ram_address <= 16'h0000;
    end else begin
      link.video_ram_address <= host_phys;
    end
  end
endmodule : vrag_device
`default_nettype wire

// ### rtl/vrag_host.sv
// Host end: passes on the RAM planes' read data and scrolls at retrace.
// Assumes the device end drives the retrace interrupt each frame.
`timescale 1ns/1ps
`default_nettype none
module vrag_host (
  input wire logic clk_in,
  input wire logic arst_n_in,
  vrag_if.host link,
  input wire logic scroll_req_in,
  input wire logic [7:0] red_in,
  input wire logic [7:0] green_in,
  input wire logic [7:0] blue_in,
  input wire logic [15:0] host_addr_in,
  input wire logic hidden_in,
  input wire logic ram_64k_in,
  output logic scroll_pending_out,
  output logic [15:0] start_out
);
  import vrag_pkg::*;

  logic [15:0] start_q;
  logic load_q;

  // Scroll request held until the next retrace interrupt.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scroll_pending_out <= 1'b0;
    end else if (scroll_req_in) begin
      scroll_pending_out <= 1'b1;
    end else if (link.vert_irq) begin
      scroll_pending_out <= 1'b0;
    end
  end

  // Start advances by one row stride only inside retrace.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_q <= START_RESET;
      load_q <= 1'b0;
    end else begin
      load_q <= 1'b0;
      if (link.vert_irq && link.retrace && scroll_pending_out) begin // R11 R10
        start_q <= start_q + 16'(ROW_STRIDE); // R9
        load_q <= 1'b1;
      end
    end
  end

  // Plane data and host address pass straight to the link.
  assign link.start_address = start_q;
  assign link.start_load = load_q;
  assign link.plane_red = red_in;
  assign link.plane_green = green_in;
  assign link.plane_blue = blue_in;
  assign link.host_logical_address = host_addr_in;
  assign link.hidden_select = hidden_in; // R19
  assign link.ram_64k = ram_64k_in;
  assign start_out = start_q;
endmodule : vrag_host
`default_nettype wire

// ### verif/tb_video_refresh_address_gen.sv
// Self-checking bench joining the refresh end and the host end.
// Assumes the shared package and link interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_video_refresh_address_gen;
  import vrag_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic reverse_in = 1'b0;
  logic scroll_req_in = 1'b0;
  logic [7:0] red_in = 8'h00;
  logic [7:0] green_in = 8'h00;
  logic [7:0] blue_in = 8'h00;
  logic [15:0] host_addr_in = 16'h0000;
  logic hidden_in = 1'b0;
  logic ram_64k_in = 1'b0;
  logic [2:0] rgb_out;
  logic active_out;
  logic scroll_pending_out;
  logic [15:0] start_out;
  logic [15:0] addr_q[$];
  logic [15:0] last_a = 16'h0000;
  logic [2:0] ph = 3'h0;
  logic [2:0] idx;
  logic [8:0] y;
  logic [6:0] x;
  int quiet = 0;
  int fail_count = 0;
  int checks_done = 0;
  int seed;
  vrag_if vrag_if_i ();
  vrag_device vrag_device_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .link(vrag_if_i.dev), .reverse_in(reverse_in), .rgb_out(rgb_out),
    .active_out(active_out));
  vrag_host vrag_host_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .link(vrag_if_i.host), .scroll_req_in(scroll_req_in), .red_in(red_in),
    .green_in(green_in), .blue_in(blue_in), .host_addr_in(host_addr_in),
    .hidden_in(hidden_in), .ram_64k_in(ram_64k_in),
    .scroll_pending_out(scroll_pending_out), .start_out(start_out));
  vrag_props vrag_props_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .refresh_ram_address(vrag_if_i.refresh_ram_address),
    .retrace(vrag_if_i.retrace), .vert_irq(vrag_if_i.vert_irq),
    .start_address(vrag_if_i.start_address),
    .start_load(vrag_if_i.start_load),
    .video_ram_address(vrag_if_i.video_ram_address),
    .ram_64k(vrag_if_i.ram_64k));
  // Free-running 10 MHz clock.
  always #50 clk_in = ~clk_in;
  // Host view: row y of 128 columns, column x, folded into plane bytes.
  function automatic logic [15:0] remap(input logic [8:0] yy,
    input logic [6:0] xx, input logic hid, input logic big);
    logic [15:0] p;
    p = 16'((yy >> 4) * 1280) + {5'h00, xx, 4'h0} + {12'h000, yy[3:0]};
    if (hid && big) begin
      p = p + 16'h8000;
    end
    if (!big) begin
      p[15] = 1'b0;
    end
    return p;
  endfunction : remap
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_pix(input logic [2:0] got, input logic [2:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t pixel got %b exp %b", $time, got, exp);
    end
  endtask : check_pix
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // Watches settled outputs: each new address takes the oldest note.
  always @(posedge clk_in) begin
    #20;
    quiet = quiet + 1;
    if (arst_n_in && vrag_if_i.refresh_ram_address !== last_a) begin
      ph = 3'h0;
      if (addr_q.size() > 0) begin
        check_word(vrag_if_i.refresh_ram_address, addr_q.pop_front());
      end
    end else begin
      ph = ph + 3'h1;
    end
    last_a = vrag_if_i.refresh_ram_address;
    idx = 3'h1 - ph;
    if (quiet > 20 && active_out === 1'b1) begin
      check_pix(rgb_out, {red_in[idx], green_in[idx], blue_in[idx]}
        ^ {3{reverse_in}});
    end
  end
  // Gives up if the walk over two character rows never finishes.
  initial begin
    #2000000;
    fail_count++;
    conclude();
  end
  // Notes the expected walk, then drives pixels, remaps and a scroll request that stays pending.
  initial begin
    seed = $urandom(32'h4099);
    for (int r = 0; r < 2; r++) begin
      for (int s = 0; s < 9; s++) begin
        for (int c = 0; c < 80; c++) begin
          if (r + s + c > 0) begin
            addr_q.push_back(16'(r * 1280 + c * 16 + s));
          end
        end
      end
    end
    repeat (10) @(negedge clk_in);
    arst_n_in = 1'b1;
    check_word(start_out, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      red_in = 8'($urandom);
      green_in = 8'($urandom);
      blue_in = 8'($urandom);
      reverse_in = i[0];
      quiet = 0;
      scroll_req_in = (i == 3);
      for (int k = 0; k < 12; k++) begin
        y = 9'($urandom_range(399));
        x = 7'($urandom_range(79));
        hidden_in = 1'($urandom);
        ram_64k_in = 1'($urandom);
        host_addr_in = {y, x};
        repeat (4) @(negedge clk_in);
        scroll_req_in = 1'b0;
        check_word(vrag_if_i.video_ram_address,
          remap(y, x, hidden_in, ram_64k_in));
      end
      repeat (100) @(negedge clk_in);
    end
    check_word({15'h0000, scroll_pending_out}, 16'h0001);
    check_word(start_out, 16'h0000);
    while (addr_q.size() > 0) begin
      @(negedge clk_in);
    end
    conclude();
  end
endmodule : tb_video_refresh_address_gen
`default_nettype wire

// ### verif/vrag_props.sv
// Concurrent checks on the link between the refresh and host ends.
// Assumes one clock domain with an active low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module vrag_props (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [15:0] refresh_ram_address,
  input wire logic retrace,
  input wire logic vert_irq,
  input wire logic [15:0] start_address,
  input wire logic start_load,
  input wire logic [15:0] video_ram_address,
  input wire logic ram_64k
);
  // Every check runs on the one clock and is idle during reset.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  byte_hold_a: assert property (
    !retrace && $changed(refresh_ram_address) |=>
    $stable(refresh_ram_address) [*7]) else $error("byte held short");
  scan_range_a: assert property (
    !retrace |-> refresh_ram_address[3:0] <= 4'h8) else $error("scan > 8");
  col_step_a: assert property (
    !retrace && !$past(retrace) && $changed(refresh_ram_address) &&
    refresh_ram_address[3:0] == $past(refresh_ram_address[3:0]) |->
    refresh_ram_address == $past(refresh_ram_address) + 16'h0010)
    else $error("column step wrong");
  scan_step_a: assert property (
    !retrace && !$past(retrace) && $changed(refresh_ram_address) &&
    $past(refresh_ram_address[3:0]) != 4'h8 &&
    refresh_ram_address[3:0] != $past(refresh_ram_address[3:0]) |->
    refresh_ram_address == $past(refresh_ram_address) - 16'h04ef)
    else $error("scan step wrong");
  row_step_a: assert property (
    !retrace && $changed(refresh_ram_address) &&
    $past(refresh_ram_address[3:0]) == 4'h8 &&
    refresh_ram_address[3:0] != $past(refresh_ram_address[3:0]) |->
    refresh_ram_address == $past(refresh_ram_address) + 16'h0008)
    else $error("row step wrong");
  irq_pulse_a: assert property (
    vert_irq |=> !vert_irq) else $error("irq too long");
  irq_retrace_a: assert property (
    $rose(retrace) |-> ##[0:1] vert_irq) else $error("irq missing");
  start_hold_a: assert property (
    $changed(start_address) || start_load |-> retrace)
    else $error("start moved in display");
  start_reload_a: assert property (
    $fell(retrace) |-> ##[0:2] refresh_ram_address == start_address)
    else $error("no reload");
  wrap_small_a: assert property (
    !ram_64k && !$past(ram_64k) |-> !video_ram_address[15])
    else $error("bit 15 in 32k mode");
endmodule : vrag_props
`default_nettype wire
